// ---- design/asca_pkg.sv ----
// Constants and types for the asynchronous serial adapter.
// Assumes one 50 MHz system clock and bus/serial pins sampled on it.
package asca_pkg;
   // Register select codes
   localparam logic [1:0] SEL_DATA   = 2'h0;
   localparam logic [1:0] SEL_STATUS = 2'h1;
   localparam logic [1:0] SEL_CMD    = 2'h2;
   localparam logic [1:0] SEL_CTRL   = 2'h3;

   // Reset values
   localparam logic [7:0] CMD_RST    = 8'h00;
   localparam logic [7:0] CTRL_RST   = 8'h00;

   // Command field positions
   localparam int CMD_DTR      = 0;
   localparam int CMD_RXI_DIS  = 1;
   localparam int CMD_TXC_LO   = 2;
   localparam int CMD_ECHO     = 4;
   localparam int CMD_PAR_EN   = 5;
   localparam int CMD_PAR_EVEN = 6;
   localparam logic [1:0] TXC_RTS_OFF = 2'h0;
   localparam logic [1:0] TXC_IRQ_ON  = 2'h1;

   // Control field positions
   localparam int CTRL_BAUD_LO = 0;
   localparam int CTRL_RXSRC   = 4;
   localparam int CTRL_WL_LO   = 5;
   localparam int CTRL_STOP    = 7;
   localparam logic [3:0] BAUD_EXT = 4'h0;

   // Status bit positions
   localparam int ST_PE   = 0;
   localparam int ST_FE   = 1;
   localparam int ST_OVR  = 2;
   localparam int ST_RDRF = 3;
   localparam int ST_TDRE = 4;
   localparam int ST_DCD  = 5;
   localparam int ST_DSR  = 6;
   localparam int ST_IRQ  = 7;

   // Reference and 16x oversampling
   localparam int         REF_HZ   = 1843200;
   localparam logic [4:0] OVS      = 5'h10;
   localparam logic [4:0] OVS_HALF = 5'h08;
   localparam logic [5:0] STOP_1   = 6'h10;
   localparam logic [5:0] STOP_15  = 6'h18;
   localparam logic [5:0] STOP_2   = 6'h20;

   // Divisors of the reference for each 16x rate, index = baud code
   typedef logic [11:0] asca_div_t;
   localparam asca_div_t BAUD_DIV [16] = '{
      12'h001, 12'h900, 12'h600, 12'h417, 12'h359, 12'h300, 12'h180, 12'h0c0,
      12'h060, 12'h040, 12'h030, 12'h020, 12'h018, 12'h010, 12'h00c, 12'h006};

   typedef enum logic [2:0] {
      ASCA_IDLE   = 3'b000,
      ASCA_START  = 3'b001,
      ASCA_DATA   = 3'b010,
      ASCA_PARITY = 3'b011,
      ASCA_STOP   = 3'b100
   } asca_state_t;

   // Character format decoded from control and command
   typedef struct packed {
      logic [3:0] nbits;
      logic       par_en;
      logic       par_even;
      logic [5:0] stop_ticks;
   } asca_fmt_t;
endpackage : asca_pkg

// ---- design/asca_adapter.sv ----
// Asynchronous serial adapter: 8-bit processor bus slave, transmitter,
// receiver, baud generator and modem lines in one module.
// Assumes all inputs are synchronous to clk; the reference clock and the
// external receive clock are sampled and edge-detected, so both must stay
// well below half the system clock rate.
`timescale 1ns/1ps
module asca_adapter (
   // System
   input  wire logic       clk,
   input  wire logic       nrst,
   // Processor bus
   input  wire logic       hw_reset_n,
   input  wire logic       bus_phase_clk,
   input  wire logic       read_not_write,
   input  wire logic       select_active_high,
   input  wire logic       select_active_low,
   input  wire logic       reg_select_lsb,
   input  wire logic       reg_select_msb,
   input  wire logic [7:0] host_data_lines_i,
   output logic      [7:0] host_data_lines_o,
   output logic            host_data_lines_oe,
   output logic            irq_n_o,
   output logic            irq_n_oe,
   // Reference and receive clock
   input  wire logic       reference_clock_in,
   output logic            reference_osc_out,
   input  wire logic       receive_16x_clock_i,
   output logic            receive_16x_clock_o,
   output logic            receive_16x_clock_oe,
   // Serial and modem
   output logic            txd,
   input  wire logic       rxd,
   output logic            rts_n,
   input  wire logic       cts_n,
   output logic            dtr_n,
   input  wire logic       dsr_n,
   input  wire logic       dcd_n
);
   logic                    rst;
   logic                    phi_q, rxc_q, ref_q;
   logic                    phi_rise, phi_fall, sel, acc_rd, acc_wr;
   logic [1:0]              rs;
   logic [7:0]              cmd_q, ctrl_q, tdr_q, rdr_q, rd_q;
   logic [7:0]              status;
   logic                    pe_q, fe_q, ovr_q, rdrf_q, tdre_q, irq_q;
   logic                    dsr_q, dcd_q;
   logic [11:0]             bcnt_q;
   logic                    tick_tx, tick_rx, ref_edge;
   asca_pkg::asca_fmt_t     fmt;
   logic                    tx_irq_en, rx_irq_en, echo;
   // Transmitter
   asca_pkg::asca_state_t   tx_st_q;
   logic [5:0]              tx_tk_q;
   logic [3:0]              tx_bit_q;
   logic [7:0]              tx_sh_q;
   logic                    tx_par_q, tx_line_q, tx_load;
   // Receiver
   asca_pkg::asca_state_t   rx_st_q;
   logic [4:0]              rx_tk_q;
   logic [3:0]              rx_bit_q;
   logic [7:0]              rx_sh_q;
   logic                    rx_par_q, rx_done, rx_bad_stop, rx_bad_par;

   // Either reset pin initialises the block
   assign rst = !nrst || !hw_reset_n;

   // Bus: latch read data on the phase rise, commit on the phase fall
   assign rs       = {reg_select_msb, reg_select_lsb};
   assign sel      = select_active_high && !select_active_low;
   assign phi_rise = bus_phase_clk && !phi_q;
   assign phi_fall = !bus_phase_clk && phi_q;
   assign acc_rd   = phi_fall && sel && read_not_write;
   assign acc_wr   = phi_fall && sel && !read_not_write;

   always_ff @(posedge clk) begin
      if (rst) begin
         phi_q <= 1'b0;
         rxc_q <= 1'b0;
         ref_q <= 1'b0;
      end else begin
         phi_q <= bus_phase_clk;
         rxc_q <= receive_16x_clock_i;
         ref_q <= reference_clock_in;
      end
   end

   assign status = {irq_q, dsr_q, dcd_q, tdre_q, rdrf_q, ovr_q, fe_q, pe_q};

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q <= 8'h00;
      end else if (phi_rise && sel && read_not_write) begin
         unique case (rs)
            asca_pkg::SEL_DATA:   rd_q <= rdr_q;
            asca_pkg::SEL_STATUS: rd_q <= status;
            asca_pkg::SEL_CMD:    rd_q <= cmd_q;
            asca_pkg::SEL_CTRL:   rd_q <= ctrl_q;
         endcase
      end
   end

   // Driven only while a selected read is in its phase-high period
   assign host_data_lines_o  = rd_q;
   assign host_data_lines_oe = bus_phase_clk && phi_q && sel && read_not_write;

   // Command and control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_q  <= asca_pkg::CMD_RST;
         ctrl_q <= asca_pkg::CTRL_RST;
      end else if (acc_wr) begin
         unique case (rs)
            asca_pkg::SEL_STATUS: cmd_q[4:0] <= 5'h00;
            asca_pkg::SEL_CMD:    cmd_q      <= host_data_lines_i;
            asca_pkg::SEL_CTRL:   ctrl_q     <= host_data_lines_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tdr_q <= 8'h00;
      end else if (acc_wr && rs == asca_pkg::SEL_DATA) begin
         tdr_q <= host_data_lines_i;
      end
   end

   // Format decode
   always_comb begin
      fmt.nbits    = 4'h8 - {2'b00, ctrl_q[asca_pkg::CTRL_WL_LO +: 2]};
      fmt.par_en   = cmd_q[asca_pkg::CMD_PAR_EN];
      fmt.par_even = cmd_q[asca_pkg::CMD_PAR_EVEN];
      if (!ctrl_q[asca_pkg::CTRL_STOP]) begin
         fmt.stop_ticks = asca_pkg::STOP_1;
      end else if (fmt.nbits == 4'h5 && !fmt.par_en) begin
         fmt.stop_ticks = asca_pkg::STOP_15;
      end else if (fmt.nbits == 4'h8 && fmt.par_en) begin
         fmt.stop_ticks = asca_pkg::STOP_1;
      end else begin
         fmt.stop_ticks = asca_pkg::STOP_2;
      end
   end

   assign echo      = cmd_q[asca_pkg::CMD_ECHO] &&
                      cmd_q[asca_pkg::CMD_TXC_LO +: 2] == asca_pkg::TXC_RTS_OFF;
   assign tx_irq_en = cmd_q[asca_pkg::CMD_TXC_LO +: 2] == asca_pkg::TXC_IRQ_ON;
   assign rx_irq_en = !cmd_q[asca_pkg::CMD_RXI_DIS];

   // Baud generator: reference edges divided to a 16x tick
   assign ref_edge = reference_clock_in && !ref_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         bcnt_q <= 12'h000;
      end else if (ref_edge) begin
         if (bcnt_q >= asca_pkg::BAUD_DIV[ctrl_q[asca_pkg::CTRL_BAUD_LO +: 4]] - 12'h001) begin
            bcnt_q <= 12'h000;
         end else begin
            bcnt_q <= bcnt_q + 12'h001;
         end
      end
   end

   // External mode uses every reference edge as the 16x clock
   assign tick_tx = ref_edge && bcnt_q == 12'h000;
   assign tick_rx = ctrl_q[asca_pkg::CTRL_RXSRC] ? tick_tx
                                                 : (receive_16x_clock_i && !rxc_q);
   assign receive_16x_clock_oe = ctrl_q[asca_pkg::CTRL_RXSRC];
   assign receive_16x_clock_o  = bcnt_q <
      {1'b0, asca_pkg::BAUD_DIV[ctrl_q[asca_pkg::CTRL_BAUD_LO +: 4]][11:1]};
   assign reference_osc_out    = !ref_q;

   // Transmitter
   assign tx_load = tx_st_q == asca_pkg::ASCA_IDLE && !tdre_q && !cts_n &&
                    cmd_q[asca_pkg::CMD_DTR];
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st_q   <= asca_pkg::ASCA_IDLE;
         tx_tk_q   <= 6'h00;
         tx_bit_q  <= 4'h0;
         tx_sh_q   <= 8'h00;
         tx_par_q  <= 1'b0;
         tx_line_q <= 1'b1;
      end else if (tx_load) begin
         tx_st_q   <= asca_pkg::ASCA_START;
         tx_tk_q   <= 6'h00;
         tx_sh_q   <= tdr_q;
         tx_par_q  <= !fmt.par_even;
         tx_line_q <= 1'b0;
      end else if (tick_tx && tx_st_q != asca_pkg::ASCA_IDLE) begin
         tx_tk_q <= tx_tk_q + 6'h01;
         unique case (tx_st_q)
            asca_pkg::ASCA_START: if (tx_tk_q == 6'h0f) begin
               tx_st_q   <= asca_pkg::ASCA_DATA;
               tx_tk_q   <= 6'h00;
               tx_bit_q  <= 4'h1;
               tx_line_q <= tx_sh_q[0];
               tx_par_q  <= tx_par_q ^ tx_sh_q[0];
               tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
            end
            asca_pkg::ASCA_DATA: if (tx_tk_q == 6'h0f) begin
               tx_tk_q <= 6'h00;
               if (tx_bit_q == fmt.nbits) begin
                  tx_st_q   <= fmt.par_en ? asca_pkg::ASCA_PARITY : asca_pkg::ASCA_STOP;
                  tx_line_q <= fmt.par_en ? tx_par_q : 1'b1;
               end else begin
                  tx_bit_q  <= tx_bit_q + 4'h1;
                  tx_line_q <= tx_sh_q[0];
                  tx_par_q  <= tx_par_q ^ tx_sh_q[0];
                  tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
               end
            end
            asca_pkg::ASCA_PARITY: if (tx_tk_q == 6'h0f) begin
               tx_st_q   <= asca_pkg::ASCA_STOP;
               tx_tk_q   <= 6'h00;
               tx_line_q <= 1'b1;
            end
            asca_pkg::ASCA_STOP: if (tx_tk_q == fmt.stop_ticks - 6'h01) begin
               tx_st_q <= asca_pkg::ASCA_IDLE;
            end
            default: tx_st_q <= asca_pkg::ASCA_IDLE;
         endcase
      end
   end

   // Echo mode loops the receive line straight back out
   assign txd = echo ? rxd : tx_line_q;

   // Receiver
   assign rx_done     = tick_rx && rx_st_q == asca_pkg::ASCA_STOP && rx_tk_q == asca_pkg::OVS - 5'h01;
   assign rx_bad_stop = !rxd;
   // Running sum of data and parity: odd is an error under even, even under odd
   assign rx_bad_par  = fmt.par_en && (rx_par_q == fmt.par_even);
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_st_q  <= asca_pkg::ASCA_IDLE;
         rx_tk_q  <= 5'h00;
         rx_bit_q <= 4'h0;
         rx_sh_q  <= 8'h00;
         rx_par_q <= 1'b0;
      end else if (tick_rx) begin
         rx_tk_q <= rx_tk_q + 5'h01;
         unique case (rx_st_q)
            asca_pkg::ASCA_IDLE: begin
               rx_tk_q <= 5'h00;
               if (!rxd && cmd_q[asca_pkg::CMD_DTR]) begin
                  rx_st_q <= asca_pkg::ASCA_START;
               end
            end
            asca_pkg::ASCA_START: if (rx_tk_q == asca_pkg::OVS_HALF - 5'h02) begin
               // Half a bit in: a high line means a glitch, not a start
               rx_st_q  <= rxd ? asca_pkg::ASCA_IDLE : asca_pkg::ASCA_DATA;
               rx_tk_q  <= 5'h00;
               rx_bit_q <= 4'h0;
               rx_par_q <= 1'b0;
               rx_sh_q  <= 8'h00;
            end
            asca_pkg::ASCA_DATA: if (rx_tk_q == asca_pkg::OVS - 5'h01) begin
               rx_tk_q  <= 5'h00;
               rx_sh_q  <= {rxd, rx_sh_q[7:1]};
               rx_par_q <= rx_par_q ^ rxd;
               rx_bit_q <= rx_bit_q + 4'h1;
               if (rx_bit_q == fmt.nbits - 4'h1) begin
                  rx_st_q <= fmt.par_en ? asca_pkg::ASCA_PARITY : asca_pkg::ASCA_STOP;
               end
            end
            asca_pkg::ASCA_PARITY: if (rx_tk_q == asca_pkg::OVS - 5'h01) begin
               rx_tk_q  <= 5'h00;
               rx_par_q <= rx_par_q ^ rxd;
               rx_st_q  <= asca_pkg::ASCA_STOP;
            end
            asca_pkg::ASCA_STOP: if (rx_done) begin
               rx_st_q <= asca_pkg::ASCA_IDLE;
            end
            default: rx_st_q <= asca_pkg::ASCA_IDLE;
         endcase
      end
   end

   // Receive data is right justified; an overrun keeps the unread byte
   always_ff @(posedge clk) begin
      if (rst) begin
         rdr_q <= 8'h00;
      end else if (rx_done && !rdrf_q) begin
         rdr_q <= rx_sh_q >> (4'h8 - fmt.nbits);
      end
   end

   // Status flags; a hardware set wins over a same-cycle clear, except empty, where a data write wins over the load
   always_ff @(posedge clk) begin
      if (rst) begin
         pe_q   <= 1'b0;
         fe_q   <= 1'b0;
         ovr_q  <= 1'b0;
         rdrf_q <= 1'b0;
         tdre_q <= 1'b1;
      end else begin
         if (rx_done) begin
            pe_q  <= rx_bad_par;
            fe_q  <= rx_bad_stop;
         end
         if (rx_done && rdrf_q) begin
            ovr_q <= 1'b1;
         end else if (acc_wr && rs == asca_pkg::SEL_STATUS) begin
            ovr_q <= 1'b0;
         end
         if (rx_done && !rdrf_q) begin
            rdrf_q <= 1'b1;
         end else if (acc_rd && rs == asca_pkg::SEL_DATA) begin
            rdrf_q <= 1'b0;
         end
         // A write in the load cycle brings fresh data, so empty stays low
         if (acc_wr && rs == asca_pkg::SEL_DATA) begin
            tdre_q <= 1'b0;
         end else if (tx_load) begin
            tdre_q <= 1'b1;
         end
      end
   end

   // Modem inputs follow the pins, also through reset
   always_ff @(posedge clk) begin
      dsr_q <= dsr_n;
      dcd_q <= dcd_n;
   end

   // Interrupt: with DTR on, set by an enabled receive into an empty buffer, enabled tx load or modem change; cleared by a status read
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else if (cmd_q[asca_pkg::CMD_DTR] &&
                   ((rx_done && !rdrf_q && rx_irq_en) ||
                    (tx_load && tx_irq_en) ||
                    (dsr_q != dsr_n) || (dcd_q != dcd_n))) begin
         irq_q <= 1'b1;
      end else if (acc_rd && rs == asca_pkg::SEL_STATUS) begin
         irq_q <= 1'b0;
      end
   end

   assign irq_n_o  = 1'b0;
   assign irq_n_oe = irq_q;

   // Modem outputs
   assign rts_n = cmd_q[asca_pkg::CMD_TXC_LO +: 2] == asca_pkg::TXC_RTS_OFF;
   assign dtr_n = !cmd_q[asca_pkg::CMD_DTR];
endmodule : asca_adapter

// ---- testbench/asca_adapter_properties.sv ----
// Port-level properties of the asynchronous serial adapter.
// Assumes it is bound to asca_adapter and sees nothing but its ports.
`timescale 1ns/1ps
module asca_props (
   // System
   input wire logic       clk,
   input wire logic       nrst,
   // Processor bus
   input wire logic       hw_reset_n,
   input wire logic       bus_phase_clk,
   input wire logic       read_not_write,
   input wire logic       select_active_high,
   input wire logic       select_active_low,
   input wire logic       reg_select_lsb,
   input wire logic       reg_select_msb,
   input wire logic [7:0] host_data_lines_i,
   input wire logic [7:0] host_data_lines_o,
   input wire logic       host_data_lines_oe,
   input wire logic       irq_n_o,
   input wire logic       irq_n_oe,
   // Clocks and serial
   input wire logic       receive_16x_clock_oe,
   input wire logic       txd,
   input wire logic       rts_n,
   input wire logic       dtr_n
);
   logic sel, wr_cmd, wr_ctl;
   assign sel    = select_active_high && !select_active_low;
   assign wr_cmd = sel && !read_not_write && reg_select_msb && !reg_select_lsb;
   assign wr_ctl = sel && !read_not_write && reg_select_msb && reg_select_lsb;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !hw_reset_n);
   AST_OE_SEL: assert property (host_data_lines_oe |-> bus_phase_clk && sel && read_not_write)
      else $error("data lines driven outside a selected read");
   AST_OE_ON: assert property ($past(bus_phase_clk) && bus_phase_clk && sel && read_not_write
      |-> host_data_lines_oe) else $error("selected read not driven");
   AST_IRQ_OD: assert property (!irq_n_oe || !irq_n_o)
      else $error("interrupt line driven high");
   AST_DTR: assert property ($fell(bus_phase_clk) && wr_cmd |=>
      dtr_n == !$past(host_data_lines_i[0])) else $error("ready line wrong");
   AST_RTS: assert property ($fell(bus_phase_clk) && wr_cmd |=>
      rts_n == ($past(host_data_lines_i[3:2]) == 2'h0)) else $error("send request wrong");
   AST_RXC_OE: assert property ($fell(bus_phase_clk) && wr_ctl |=>
      receive_16x_clock_oe == $past(host_data_lines_i[4])) else $error("rx clock dir wrong");
   AST_RST_OUT: assert property (disable iff (1'h0) (!nrst || !hw_reset_n) |=>
      txd && dtr_n && rts_n && !irq_n_oe && !receive_16x_clock_oe) else $error("reset state");
   AST_RD_STAND: assert property (host_data_lines_oe && $past(host_data_lines_oe)
      |-> $stable(host_data_lines_o)) else $error("read data moved");
   cover property ($fell(bus_phase_clk) && wr_cmd);
   cover property (host_data_lines_oe);
   cover property ($fell(txd));
endmodule : asca_props
bind asca_adapter asca_props chk_u (.*);

// ---- testbench/asca_modem.sv ----
// Modem-side model: reference oscillator, external 16x clock and a
// loopback of the serial output onto the serial input.
`timescale 1ns/1ps
module asca_modem (
   // Serial
   input  wire logic txd,
   output logic      rxd,
   // Clocks
   output logic      ref_clk,
   output logic      rxc_ext
);
   initial ref_clk = 1'h0;
   always #271.267 ref_clk = ~ref_clk;
   assign rxc_ext = ref_clk;
   // Loopback keeps bit order and level, so received bytes mirror sent ones
   assign rxd = txd;
endmodule : asca_modem

// ---- testbench/async_serial_comm_adapter_tb.sv ----
// Self-checking bench for the serial adapter, register bus plus loopback.
// Assumes the modem model loops the serial line and supplies the reference.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module async_serial_comm_adapter_tb;
   logic       clk = 1'h0, nrst = 1'h0, hw_reset_n = 1'h1, phase = 1'h0;
   logic       rw = 1'h1, cs_hi = 1'h0, cs_lo = 1'h1, cts_n = 1'h0;
   logic       dsr_n = 1'h0, dcd_n = 1'h1;
   logic [1:0] rs = 2'h0;
   logic [7:0] wdat = 8'h00, d_o, rd, st;
   logic       d_oe, irq_o, irq_oe, rxc_o, rxc_oe, txd, rxd, rts_n, dtr_n, refc, rxe;
   int         err_count = 0, n_checks = 0;
   int         wait_n = 0, n0 = 0, rxc_rises = 0;
   wire [7:0]  dbus = d_oe ? d_o : wdat;
   wire        rxc_pin = rxc_oe ? rxc_o : rxe;
   wire        irq_line = irq_oe ? irq_o : 1'h1;
   always #10 clk = ~clk;
   always @(posedge rxc_pin) rxc_rises++;
   asca_adapter dut_u (
      .clk(clk), .nrst(nrst), .hw_reset_n(hw_reset_n), .bus_phase_clk(phase),
      .read_not_write(rw), .select_active_high(cs_hi), .select_active_low(cs_lo),
      .reg_select_lsb(rs[0]), .reg_select_msb(rs[1]), .host_data_lines_i(dbus),
      .host_data_lines_o(d_o), .host_data_lines_oe(d_oe), .irq_n_o(irq_o),
      .irq_n_oe(irq_oe), .reference_clock_in(refc), .reference_osc_out(),
      .receive_16x_clock_i(rxc_pin), .receive_16x_clock_o(rxc_o),
      .receive_16x_clock_oe(rxc_oe), .txd(txd), .rxd(rxd), .rts_n(rts_n),
      .cts_n(cts_n), .dtr_n(dtr_n), .dsr_n(dsr_n), .dcd_n(dcd_n));
   asca_modem modem_u (.txd(txd), .rxd(rxd), .ref_clk(refc), .rxc_ext(rxe));
   // One access per phase-high window; selects held until after the fall
   task automatic acc(input logic s, input logic r, input logic [1:0] a,
                      input logic [7:0] w, output logic [7:0] q);
      @(negedge clk);
      rw = r; rs = a; wdat = w; cs_hi = s; cs_lo = !s; phase = 1'h1;
      repeat (3) @(negedge clk);
      q = d_o;
      phase = 1'h0;
      repeat (2) @(negedge clk);
      cs_hi = 1'h0; cs_lo = 1'h1;
   endtask : acc
   task automatic wr(input logic [1:0] a, input logic [7:0] w);
      acc(1'h1, 1'h0, a, w, rd);
   endtask : wr
   task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string nm);
      acc(1'h1, 1'h1, a, 8'h00, rd);
      `CHK(nm, e, rd)
   endtask : rdc
   // Bounded poll: a character takes about 4500 clocks at the external rate
   task automatic poll(input int b);
      st = 8'h00;
      for (int k = 0; k < 1500 && st[b] !== 1'h1; k++) acc(1'h1, 1'h1, asca_pkg::SEL_STATUS, 8'h00, st);
   endtask : poll
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      // Tests need about 52000 clocks; the slow internal-rate character dominates
      repeat (80000) @(posedge clk);
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'h1;
      rdc(asca_pkg::SEL_CMD, asca_pkg::CMD_RST, "cmd");
      rdc(asca_pkg::SEL_CTRL, asca_pkg::CTRL_RST, "ctrl");
      rdc(asca_pkg::SEL_STATUS, 8'h30, "status");
      wr(asca_pkg::SEL_CMD, 8'h09);
      `CHK("dtr_n", 1'h0, dtr_n)
      `CHK("rts_n", 1'h0, rts_n)
      acc(1'h0, 1'h0, asca_pkg::SEL_CMD, 8'h00, rd);
      rdc(asca_pkg::SEL_CMD, 8'h09, "cmd");
      for (int i = 0; i < 4; i++) begin
         // Odd passes clock the receiver from the tx rate, even ones from the pin
         wr(asca_pkg::SEL_CTRL, {i == 3, i[1:0], i[0], 4'h0});
         rdc(asca_pkg::SEL_CTRL, {i == 3, i[1:0], i[0], 4'h0}, "ctrl");
         wr(asca_pkg::SEL_CMD, i[0] ? 8'h29 : 8'h09);
         wr(asca_pkg::SEL_DATA, 8'hff);
         for (int k = 0; k < 8000 && irq_line !== 1'h0; k++) @(negedge clk);
         `CHK("irq", 1'h0, irq_line)
         acc(1'h1, 1'h1, asca_pkg::SEL_STATUS, 8'h00, st);
         `CHK("status", 8'h88, st & 8'h8f)
         rdc(asca_pkg::SEL_DATA, 8'hff >> i, "rx");
      end
      wr(asca_pkg::SEL_CTRL, 8'h10);
      wr(asca_pkg::SEL_CMD, 8'h09);
      cts_n = 1'h1;
      wr(asca_pkg::SEL_DATA, 8'h3c);
      repeat (600) @(negedge clk);
      acc(1'h1, 1'h1, asca_pkg::SEL_STATUS, 8'h00, st);
      `CHK("tx_empty", 1'h0, st[4])
      cts_n = 1'h0;
      poll(3);
      wr(asca_pkg::SEL_DATA, 8'hc3);
      poll(2);
      `CHK("overrun", 1'h1, st[2])
      rdc(asca_pkg::SEL_DATA, 8'h3c, "rx");
      wr(asca_pkg::SEL_CMD, 8'hff);
      wr(asca_pkg::SEL_STATUS, 8'h5a);
      rdc(asca_pkg::SEL_CMD, 8'he0, "cmd");
      rdc(asca_pkg::SEL_CTRL, 8'h10, "ctrl");
      acc(1'h1, 1'h1, asca_pkg::SEL_STATUS, 8'h00, st);
      `CHK("overrun", 1'h0, st[2])
      wr(asca_pkg::SEL_CMD, 8'h09);
      acc(1'h1, 1'h1, asca_pkg::SEL_STATUS, 8'h00, st);
      dcd_n = 1'h0;
      repeat (3) @(negedge clk);
      `CHK("irq_dcd", 1'h0, irq_line)
      acc(1'h1, 1'h1, asca_pkg::SEL_STATUS, 8'h00, st);
      `CHK("status_dcd", 8'h80, st & 8'he0)
      `CHK("irq_release", 1'h1, irq_line)
      // Let the last stop bit drain before the rate is slowed down
      repeat (300) @(negedge clk);
      wr(asca_pkg::SEL_CTRL, 8'h1f);
      wr(asca_pkg::SEL_DATA, 8'ha5);
      n0 = rxc_rises;
      for (wait_n = 0; wait_n < 30000 && irq_line !== 1'h0; wait_n++) @(negedge clk);
      // 19200 baud: stop-bit centre comes about 9.5 bit times after the load
      `CHK("rate", 1'h1, wait_n > 24000 && wait_n < 25500)
      `CHK("rxc_out", 1'h1, (rxc_rises - n0) > 140 && (rxc_rises - n0) < 160)
      rdc(asca_pkg::SEL_DATA, 8'ha5, "rx_int");
      hw_reset_n = 1'h0;
      repeat (2) @(negedge clk);
      hw_reset_n = 1'h1;
      rdc(asca_pkg::SEL_CTRL, asca_pkg::CTRL_RST, "ctrl");
      print_verdict();
   end
endmodule : async_serial_comm_adapter_tb
